// ### hw/imdr_pkg.sv
// Constants, lane layout and bus carrier for the DMA-completion interrupt mode registers
package imdr_pkg;

    localparam int ADDR_W   = 32;
    localparam int DATA_W   = 32;
    localparam int N_SRC    = 4;
    localparam int N_DMA_CH = 8;
    localparam int LANE_W   = 8;
    localparam int LVL_W    = 3;

    // Word holding sources 56..59 sits just below the 60..63 word
    localparam logic [ADDR_W-1:0] WORD_A_ADDR = 32'hFFFF_E038;
    localparam logic [ADDR_W-1:0] WORD_B_ADDR = 32'hFFFF_E03C;

    // Byte lane of the first handled source in each word
    localparam int LANE_A_BASE = 2;
    localparam int LANE_B_BASE = 0;
    // Handled sources per word
    localparam int SRC_PER_WORD = 2;

    // Field positions inside one byte lane
    localparam int LVL_LSB  = 0;
    localparam int DMA_BIT  = 4;
    localparam int EDGE_LSB = 5;
    localparam int EDGE_W   = 2;

    localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h2;
    localparam logic [LVL_W-1:0]  LVL_OFF   = 3'h0;
    localparam logic [LANE_W-1:0] LANE_RST  = 8'h00;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    // Bits 7 and 3 of every lane, plus lanes not implemented here
    localparam logic [DATA_W-1:0] WORD_A_RSVD = 32'h8888_FFFF;
    localparam logic [DATA_W-1:0] WORD_B_RSVD = 32'hFFFF_8888;

    typedef struct packed {
        logic [EDGE_W-1:0] edge_sel;
        logic              dma_trigger;
        logic [LVL_W-1:0]  level_or_chan;
    } imdr_lane_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr_stb;
        logic              rd_stb;
    } imdr_bus_s;

    // Reserved lane bits are dropped on the way in
    function automatic imdr_lane_s lane_unpack(input logic [LANE_W-1:0] b);
        imdr_lane_s l;
        l.edge_sel      = b[EDGE_LSB +: EDGE_W];
        l.dma_trigger   = b[DMA_BIT];
        l.level_or_chan = b[LVL_LSB +: LVL_W];
        return l;
    endfunction

    function automatic logic [LANE_W-1:0] lane_pack(input imdr_lane_s l);
        logic [LANE_W-1:0] b;
        b                     = LANE_RST;
        b[EDGE_LSB +: EDGE_W] = l.edge_sel;
        b[DMA_BIT]            = l.dma_trigger;
        b[LVL_LSB +: LVL_W]   = l.level_or_chan;
        return b;
    endfunction

endpackage

// ### hw/imdr_lane_det.sv
// Falling-edge detector for one interrupt source lane
module imdr_lane_det (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire imdr_pkg::imdr_lane_s cfg,
    input  wire logic                 irq_in,
    output logic                      fall_hit
);
    import imdr_pkg::*;

    logic prev_r;

    // Cleared at reset so a source held low never fires without a high first
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= irq_in;
        end
    end

    // Only code 10 detects; other codes leave the source silent
    assign fall_hit = (cfg.edge_sel == EDGE_FALL) && prev_r && !irq_in;

endmodule // imdr_lane_det

// ### hw/imdr_top.sv
// Interrupt mode words for DMA-completion sources 58..61, with request routing
// Operation
// - Two-bit active-state select per lane; code 10 detects falling edges.
// - Trigger bit 0: no DMA trigger; 1: source becomes a DMA trigger.
// - Trigger bit 0: three-bit field is priority; 000 off, 001..111 levels 1..7.
// - Trigger bit 1: same field picks DMA channel 0..7.
// - Source 58 lives in byte lane 2 of the preceding word.
// - Word E03C: source 60 bits 7:0, 61 bits 15:8; bits 7,3 read zero.
module imdr_top (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire imdr_pkg::imdr_bus_s       bus,
    output logic [imdr_pkg::DATA_W-1:0]    rd_data_r,
    input  wire logic                      dma_ch2_done_irq,
    input  wire logic                      dma_ch3_done_irq,
    input  wire logic                      dma_ch4_done_irq,
    input  wire logic                      dma_ch5_done_irq,
    output logic [imdr_pkg::N_SRC-1:0]     irq_req_r,
    output logic [imdr_pkg::N_SRC-1:0][imdr_pkg::LVL_W-1:0] irq_lvl_r,
    output logic [imdr_pkg::N_DMA_CH-1:0]  dma_trig_r
);
    import imdr_pkg::*;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    imdr_lane_s                lane_r [N_SRC];
    logic [N_SRC-1:0]          src_vec;
    logic [N_SRC-1:0]          hit;
    logic [N_SRC-1:0]          irq_nxt;
    logic [N_DMA_CH-1:0]       dma_nxt;
    logic                      sel_a;
    logic                      sel_b;

    // Request inputs come from on-chip DMA logic on this clock, no synchroniser
    assign src_vec = {dma_ch5_done_irq, dma_ch4_done_irq, dma_ch3_done_irq, dma_ch2_done_irq};
    assign sel_a   = (bus.addr == WORD_A_ADDR);
    assign sel_b   = (bus.addr == WORD_B_ADDR);

    // Image of one mode word as software reads it
    function automatic logic [DATA_W-1:0] word_image(input imdr_lane_s l0,
                                                     input imdr_lane_s l1,
                                                     input int base);
        logic [DATA_W-1:0] w;
        w = WORD_ZERO;
        w[LANE_W*base +: LANE_W]     = lane_pack(l0);
        w[LANE_W*(base+1) +: LANE_W] = lane_pack(l1);
        return w;
    endfunction

    // Register writes; lanes 0,1 = sources 58,59; lanes 2,3 = sources 60,61
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < N_SRC; i++) begin
                lane_r[i] <= lane_unpack(LANE_RST);
            end
        end else if (bus.wr_stb) begin
            if (sel_a) begin
                lane_r[0] <= lane_unpack(bus.wdata[LANE_W*LANE_A_BASE +: LANE_W]);
                lane_r[1] <= lane_unpack(bus.wdata[LANE_W*(LANE_A_BASE+1) +: LANE_W]);
            end else if (sel_b) begin
                lane_r[2] <= lane_unpack(bus.wdata[LANE_W*LANE_B_BASE +: LANE_W]);
                lane_r[3] <= lane_unpack(bus.wdata[LANE_W*(LANE_B_BASE+1) +: LANE_W]);
            end
        end
    end

    // Read data stand for one cycle only; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data_r <= WORD_ZERO;
        end else if (bus.rd_stb) begin
            if (sel_a) begin
                rd_data_r <= word_image(lane_r[0], lane_r[1], LANE_A_BASE);
            end else if (sel_b) begin
                rd_data_r <= word_image(lane_r[2], lane_r[3], LANE_B_BASE);
            end else begin
                rd_data_r <= WORD_ZERO;
            end
        end else begin
            rd_data_r <= WORD_ZERO;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_lane
            imdr_lane_det u_det (
                .clock    (clock),
                .rst_n    (rst_n),
                .cfg      (lane_r[g]),
                .irq_in   (src_vec[g]),
                .fall_hit (hit[g])
            );
        end
    endgenerate

    // Split each detected edge into a CPU request, a DMA trigger, or nothing at level 000
    always_comb begin
        irq_nxt = '0;
        dma_nxt = '0;
        for (int i = 0; i < N_SRC; i++) begin
            if (hit[i]) begin
                if (lane_r[i].dma_trigger) begin
                    dma_nxt[lane_r[i].level_or_chan] = 1'b1;
                end else if (lane_r[i].level_or_chan != LVL_OFF) begin
                    irq_nxt[i] = 1'b1;
                end
            end
        end
    end

    // Level is shown continuously; priority resolution lives elsewhere
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_req_r <= '0;
            irq_lvl_r <= '0;
        end else begin
            irq_req_r <= irq_nxt;
            for (int i = 0; i < N_SRC; i++) begin
                irq_lvl_r[i] <= lane_r[i].dma_trigger ? LVL_OFF : lane_r[i].level_or_chan;
            end
        end
    end

    // Two sources may share a channel; their triggers merge into one pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dma_trig_r <= '0;
        end else begin
            dma_trig_r <= dma_nxt;
        end
    end

    // Checks

    sequence fall_s(int i);
        src_vec[i] ##1 !src_vec[i];
    endsequence

    property word_b_read_p;
        (bus.rd_stb && sel_b) |=>
            rd_data_r == word_image($past(lane_r[2]), $past(lane_r[3]), LANE_B_BASE);
    endproperty

    rd_word_b_a: assert property (word_b_read_p)
        else $error("word B read data wrong");

    rd_reserved_a: assert property (((rd_data_r & WORD_A_RSVD) == WORD_ZERO)
                                    || ((rd_data_r & WORD_B_RSVD) == WORD_ZERO))
        else $error("reserved bits read nonzero");

    rd_one_cycle_a: assert property (!bus.rd_stb |=> rd_data_r == WORD_ZERO)
        else $error("read data stood past one cycle");

    wr_word_a_a: assert property ((bus.wr_stb && sel_a) |=>
                                  lane_pack(lane_r[0]) ==
                                  ($past(bus.wdata[LANE_W*LANE_A_BASE +: LANE_W]) & 8'h77))
        else $error("source 58 lane not written");

    reset_clear_a: assert property (@(posedge clock) disable iff (1'b0)
                                    !rst_n |=> (irq_req_r == '0) && (dma_trig_r == '0)
                                    && (lane_pack(lane_r[3]) == LANE_RST))
        else $error("reset did not clear state");

    // Check helpers: lanes routed to the DMA side, lanes armed for a fall
    logic [N_SRC-1:0] routed;
    logic [N_SRC-1:0] armed;

    always_comb begin
        for (int i = 0; i < N_SRC; i++) begin
            routed[i] = lane_r[i].dma_trigger;
            armed[i]  = (lane_r[i].edge_sel == EDGE_FALL);
        end
    end

    // Bus steps named once so the multi-cycle checks read as transfers
    sequence wr_a_s;
        bus.wr_stb && sel_a;
    endsequence

    sequence wr_b_s;
        bus.wr_stb && sel_b;
    endsequence

    sequence wr_none_s;
        bus.wr_stb && !sel_a && !sel_b;
    endsequence

    sequence rd_a_s;
        bus.rd_stb && sel_a;
    endsequence

    sequence rd_b_s;
        bus.rd_stb && sel_b;
    endsequence

    sequence rd_none_s;
        bus.rd_stb && !sel_a && !sel_b;
    endsequence

    // Write, one idle cycle, then a read of the same word
    sequence wr_rd_a_s;
        wr_a_s ##1 !bus.wr_stb ##1 rd_a_s;
    endsequence

    sequence wr_rd_b_s;
        wr_b_s ##1 !bus.wr_stb ##1 rd_b_s;
    endsequence

    // Reserved bits and foreign lanes read zero whatever was written
    property word_a_back_p;
        wr_rd_a_s |=> rd_data_r == ($past(bus.wdata, 3) & ~WORD_A_RSVD);
    endproperty

    property word_b_back_p;
        wr_rd_b_s |=> rd_data_r == ($past(bus.wdata, 3) & ~WORD_B_RSVD);
    endproperty

    back_word_a_a: assert property (word_a_back_p)
        else $error("word A readback differs from write");

    back_word_b_a: assert property (word_b_back_p)
        else $error("word B readback differs from write");

    wr_src59_a: assert property (wr_a_s |=>
                                 lane_pack(lane_r[1]) ==
                                 ($past(bus.wdata[LANE_W*(LANE_A_BASE+1) +: LANE_W]) & 8'h77))
        else $error("source 59 lane not written");

    wr_word_b_a: assert property (wr_b_s |=>
                                  lane_pack(lane_r[3]) ==
                                  ($past(bus.wdata[LANE_W*(LANE_B_BASE+1) +: LANE_W]) & 8'h77))
        else $error("source 61 lane not written");

    rd_unmapped_a: assert property (rd_none_s |=> rd_data_r == WORD_ZERO)
        else $error("unmapped read gave data");

    // Non-routed edges alone must leave every channel quiet
    dma_quiet_a: assert property (((hit & routed) == '0) |=> (dma_trig_r == '0))
        else $error("DMA trigger from non-routed source");

    dma_cause_a: assert property ((dma_trig_r != '0) |-> $past((hit & routed) != '0))
        else $error("DMA trigger without routed edge");

    irq_quiet_a: assert property ((hit == '0) |=> (irq_req_r == '0))
        else $error("request without detected edge");

    reset_out_a: assert property (@(posedge clock) disable iff (1'b0)
                                  !rst_n |=> (rd_data_r == WORD_ZERO) && (irq_lvl_r == '0)
                                  && (lane_pack(lane_r[0]) == LANE_RST)
                                  && (lane_pack(lane_r[1]) == LANE_RST)
                                  && (lane_pack(lane_r[2]) == LANE_RST))
        else $error("reset left outputs or lanes set");

    generate
        for (g = 0; g < N_SRC; g++) begin : g_chk
            // Lane g serves source 58+g
            property edge_to_irq_p;
                (lane_r[g].edge_sel == EDGE_FALL && !lane_r[g].dma_trigger
                 && lane_r[g].level_or_chan != LVL_OFF && src_vec[g])
                ##1 (!src_vec[g] && $stable(lane_r[g])) |=> irq_req_r[g];
            endproperty

            fall_req_a: assert property (edge_to_irq_p)
                else $error("falling edge gave no request");

            no_sel_a: assert property ((lane_r[g].edge_sel != EDGE_FALL) |=> !irq_req_r[g])
                else $error("request without falling-edge select");

            dma_block_a: assert property ((lane_r[g].dma_trigger
                                           || lane_r[g].level_or_chan == LVL_OFF)
                                          |=> !irq_req_r[g])
                else $error("request while routed or disabled");

            dma_route_a: assert property ((lane_r[g].dma_trigger && lane_r[g].edge_sel == EDGE_FALL)
                                          ##0 fall_s(g) ##0 $stable(lane_r[g])
                                          |=> dma_trig_r[$past(lane_r[g].level_or_chan)])
                else $error("DMA trigger on wrong channel");

            lvl_show_a: assert property (!routed[g]
                                         |=> irq_lvl_r[g] == $past(lane_r[g].level_or_chan))
                else $error("shown level differs from lane");

            lvl_hide_a: assert property (routed[g] |=> irq_lvl_r[g] == LVL_OFF)
                else $error("level shown while routed to DMA");

            irq_once_a: assert property (irq_req_r[g] |=> !irq_req_r[g])
                else $error("request stood past one cycle");

            irq_cause_a: assert property (irq_req_r[g] |-> $past(armed[g] && !routed[g]
                                          && lane_r[g].level_or_chan != LVL_OFF))
                else $error("request without armed lane");

            irq_pin_a: assert property (irq_req_r[g]
                                        |-> $past(!src_vec[g]) && $past(src_vec[g], 2))
                else $error("request without a falling input");

            wr_keep_a: assert property (wr_none_s |=> $stable(lane_r[g]))
                else $error("unmapped write changed a lane");
        end
    endgenerate

endmodule // imdr_top

// ### dv/imdr_src_model.sv
// Request source model: one shot per line gives one high cycle, then low
module imdr_src_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [3:0] fire,
    output logic      [3:0] src_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lines idle low, so every shot ends in exactly one falling edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            src_r <= 4'h0;
        end else begin
            src_r <= fire;
        end
    end
endmodule // imdr_src_model

// ### dv/imdr_top_tb.sv
// Self-checking bench for the DMA-completion interrupt mode words
`define CHK(g, e) chk(32'(g), 32'(e))
module imdr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import imdr_pkg::*;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] w;
        logic [31:0] e;
    } imdr_row_s;
    logic                        clock = 1'b0;
    logic                        rst_n = 1'b0;
    imdr_bus_s                   bus   = '0;
    logic [3:0]                  fire  = 4'h0;
    logic [3:0]                  src_r;
    logic [DATA_W-1:0]           rd_data_r;
    logic [N_SRC-1:0]            irq_req_r;
    logic [N_SRC-1:0][LVL_W-1:0] irq_lvl_r;
    logic [N_DMA_CH-1:0]         dma_trig_r;
    logic [31:0]                 d;
    int                          n_errors = 0;
    int                          checked  = 0;
    int                          cycles   = 0;
    // Address, write data, expected readback
    imdr_row_s rows [5] = '{
        '{32'hFFFF_E03C, 32'hFFFF_FFFF, 32'h0000_7777},
        '{32'hFFFF_E038, 32'hFFFF_FFFF, 32'h7777_0000},
        '{32'hFFFF_E034, 32'hFFFF_FFFF, 32'h0000_0000},
        '{32'hFFFF_E03C, 32'h0000_5141, 32'h0000_5141},
        '{32'hFFFF_E038, 32'h5343_0000, 32'h5343_0000}};

    imdr_src_model i_src (.clock(clock), .rst_n(rst_n), .fire(fire), .src_r(src_r));
    imdr_top i_dut (
        .clock(clock), .rst_n(rst_n), .bus(bus), .rd_data_r(rd_data_r),
        .dma_ch2_done_irq(src_r[0]), .dma_ch3_done_irq(src_r[1]),
        .dma_ch4_done_irq(src_r[2]), .dma_ch5_done_irq(src_r[3]),
        .irq_req_r(irq_req_r), .irq_lvl_r(irq_lvl_r), .dma_trig_r(dma_trig_r));

    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] w);
        @(posedge clock) bus <= '{addr: a, wdata: w, wr_stb: 1'b1, rd_stb: 1'b0};
        @(posedge clock) bus.wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clock) bus <= '{addr: a, wdata: 32'h0, wr_stb: 1'b0, rd_stb: 1'b1};
        @(posedge clock) bus.rd_stb <= 1'b0;
        @(negedge clock) v = rd_data_r;
    endtask
    task automatic shot(input logic [3:0] m);
        @(posedge clock) fire <= m;
        @(posedge clock) fire <= 4'h0;
    endtask
    // Bounded wait for any request or trigger pulse
    task automatic wait_pulse();
        for (int i = 0; i < 8; i++) begin
            @(negedge clock);
            if ((irq_req_r | dma_trig_r) !== 8'h00) break;
        end
    endtask
    task automatic tally_and_finish();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(WORD_A_ADDR, d);
        `CHK(d, 0);
        rd(WORD_B_ADDR, d);
        `CHK(d, 0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            `CHK(d, rows[i].e);
        end
        `CHK(irq_lvl_r, 12'h043);
        shot(4'hF);
        wait_pulse();
        `CHK(irq_req_r, 4'h5);
        `CHK(dma_trig_r, 8'h0A);
        @(negedge clock);
        `CHK({irq_req_r, dma_trig_r}, 0);
        // Every level code on source 58 and every channel code on source 59
        for (int c = 0; c < 8; c++) begin
            wr(WORD_A_ADDR, {8'h50 | 8'(c), 8'h40 | 8'(c), 16'h0000});
            shot(4'h3);
            wait_pulse();
            `CHK(dma_trig_r, 8'h01 << c);
            `CHK(irq_req_r, (c != 0) ? 4'h1 : 4'h0);
            `CHK(irq_lvl_r[0], c);
        end
        // Level zero and select codes 00, 01, 11 must stay silent
        wr(WORD_A_ADDR, 32'h0161_0000);
        wr(WORD_B_ADDR, 32'h0000_3140);
        shot(4'hF);
        wait_pulse();
        `CHK({irq_req_r, dma_trig_r}, 0);
        // Source 60 routed to channel 6, source 61 at level 7
        wr(WORD_B_ADDR, 32'h0000_4756);
        shot(4'hC);
        wait_pulse();
        `CHK(irq_req_r, 4'h8);
        `CHK(dma_trig_r, 8'h40);
        `CHK(irq_lvl_r, 12'hE09);
        @(posedge clock) rst_n <= 1'b0;
        @(posedge clock) rst_n <= 1'b1;
        rd(WORD_A_ADDR, d);
        `CHK(d, 0);
        `CHK(irq_lvl_r, 0);
        tally_and_finish();
    end
endmodule // imdr_top_tb
